/* core/usshp_port.v */
// Serial host port of the UART: mode 0 slave, 16-bit full-duplex frames, transmit FIFO and UART line logic.
// How it works
// - Sixteen bits in, sixteen bits out, always.
// - First two input bits pick transfer type.
// - Input bit captured on serial clock rise.
// - Bit 15 at select fall, rest on falls.
// - Short frame aborted, no register updated.
// - Frame effects follow select rise, except the receive flag clear.
// - Select fall restarts the bit counter.
// - Data output released while select is high.
// - Transmit and request outputs always driven.
// - Interrupt open drain, pulled low only.
// - Power down stops oscillator, aborts character.
// - Receive flag clears on sixteenth falling edge of a data frame.
`timescale 1ns/1ps
`include "usshp_defines.vh"

module usshp_fifo #(
  parameter W  = 8,
  parameter D  = `USSHP_FIFO_DEPTH,
  parameter AW = `USSHP_FIFO_AW
) (
  input  wire          i_clk,
  input  wire          i_srst,
  input  wire          i_flush,
  input  wire          i_wr_valid,
  output wire          o_wr_ready,
  input  wire [W-1:0]  i_wr_data,
  output wire          o_rd_valid,
  input  wire          i_rd_ready,
  output wire [W-1:0]  o_rd_data
);
  // Pointers wrap naturally, so the depth must be a power of two.
  localparam [AW:0] DEPTH = D[AW:0];
  reg  [W-1:0]  mem_q [0:D-1];
  reg  [AW-1:0] wp_q;
  reg  [AW-1:0] rp_q;
  reg  [AW:0]   cnt_q;
  wire          push;
  wire          pop;

  assign o_wr_ready = (cnt_q != DEPTH);
  assign o_rd_valid = (cnt_q != {(AW+1){1'b0}});
  assign o_rd_data  = mem_q[rp_q];
  assign push       = i_wr_valid & o_wr_ready;
  assign pop        = o_rd_valid & i_rd_ready;

  always @(posedge i_clk) begin
    if (push) begin
      mem_q[wp_q] <= i_wr_data;
    end
  end

  always @(posedge i_clk) begin
    if (i_srst || i_flush) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // usshp_fifo

module usshp_port #(
  parameter [7:0] OSC_DIV = `USSHP_OSC_DIV
) (
  input  wire I_MCLK,
  input  wire I_SRST,
  input  wire I_SCLK,
  input  wire I_CS_N,
  input  wire I_DIN,
  input  wire I_POWER_DOWN_N,
  input  wire I_RX,
  output wire O_DOUT,
  output wire O_DOUT_OE_N,
  output wire O_IRQ_N,
  output wire O_IRQ_OE_N,
  output wire O_TX,
  output wire O_RTS_N
);
  reg  [4:0]  s1_q, s2_q, cnt_q;
  reg  [15:0] in_q, sh_q, word_q;
  reg  [13:0] cfg_q;
  reg  [7:0]  osc_cnt_q, rxd_q;
  reg  [9:0]  tx_sh_q;
  reg  [8:0]  rx_sh_q;
  reg  [3:0]  tx_n_q, rx_n_q;
  reg  [19:0] tx_tmr_q, rx_tmr_q;
  reg         sck_prev_q, cs_prev_q, dout_oe_n_q, pend_q, rts_q, rts_n_q, irq_oe_n_q;
  reg         irq_n_q, osc_tick_q, r_q, tx_busy_q, tx_q, rx_busy_q, rx_new_q;
  wire        sck, cs_n, din, pd_n, rx, sck_rise, sck_fall, cs_fall, cs_rise;
  wire        rx_clr, t_room, f_valid, push_ok, wr_data;
  wire [1:0]  ty_early;
  wire [13:0] low_word;
  wire [7:0]  f_data;
  wire [19:0] bit_len;
  function [19:0] bit_ticks;
    input [3:0] b;
    begin
      bit_ticks = `USSHP_OVERSAMPLE << b;
    end
  endfunction
  assign sck      = s2_q[4];
  assign cs_n     = s2_q[3];
  assign din      = s2_q[2];
  assign pd_n     = s2_q[1];
  assign rx       = s2_q[0];
  assign sck_rise = sck & ~sck_prev_q;
  assign sck_fall = ~sck & sck_prev_q;
  assign cs_fall  = ~cs_n & cs_prev_q;
  assign cs_rise  = cs_n & ~cs_prev_q;
  assign ty_early = {in_q[0], din};
  assign low_word = ty_early[0] ? cfg_q : {6'h00, rxd_q};
  assign rx_clr   = sck_fall && !cs_n && (cnt_q == `USSHP_FRAME_BITS) && !in_q[14];
  assign wr_data  = (word_q[15:14] == `USSHP_TYPE_WR_DATA);
  assign push_ok  = pend_q && osc_tick_q && pd_n && wr_data && !word_q[`USSHP_DATA_TE_N];
  assign bit_len  = bit_ticks(cfg_q[3:0]);
  assign O_DOUT      = sh_q[15];
  assign O_DOUT_OE_N = dout_oe_n_q;
  assign O_IRQ_N     = irq_n_q;
  assign O_IRQ_OE_N  = irq_oe_n_q;
  assign O_TX        = tx_q;
  assign O_RTS_N     = rts_n_q;
  // Pins cross into the clock domain through two flip-flops.
  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      s1_q       <= 5'h0B;
      s2_q       <= 5'h0B;
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end else begin
      s1_q       <= {I_SCLK, I_CS_N, I_DIN, I_POWER_DOWN_N, I_RX};
      s2_q       <= s1_q;
      sck_prev_q <= sck;
      cs_prev_q  <= cs_n;
    end
  end

  // Serial frame engine.
  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      cnt_q       <= 5'h00;
      in_q        <= 16'h0000;
      sh_q        <= 16'h0000;
      dout_oe_n_q <= 1'b1;
      pend_q      <= 1'b0;
      word_q      <= 16'h0000;
    end else begin
      if (pend_q && osc_tick_q && pd_n && (!wr_data || word_q[`USSHP_DATA_TE_N] || t_room)) begin
        pend_q <= 1'b0;
      end
      if (cs_fall) begin
        cnt_q       <= 5'h00;
        sh_q        <= {r_q, t_room, 14'h0000};
        dout_oe_n_q <= 1'b0;
      end else if (cs_rise) begin
        dout_oe_n_q <= 1'b1;
        if (cnt_q == `USSHP_FRAME_BITS) begin
          pend_q <= 1'b1;
          word_q <= in_q;
        end
      end else if (!cs_n) begin
        if (sck_rise && cnt_q != `USSHP_FRAME_BITS) begin
          in_q  <= {in_q[14:0], din};
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == 5'h01) begin
            sh_q[14:1] <= low_word;
          end
        end
        if (sck_fall) begin
          sh_q <= {sh_q[14:0], 1'b0};
        end
      end
    end
  end
  always @(posedge I_MCLK) begin
    if (I_SRST || !pd_n) begin
      osc_cnt_q  <= 8'h00;
      osc_tick_q <= 1'b0;
    end else begin
      osc_tick_q <= (osc_cnt_q == OSC_DIV - 8'h01);
      osc_cnt_q  <= (osc_cnt_q == OSC_DIV - 8'h01) ? 8'h00 : osc_cnt_q + 8'h01;
    end
  end
  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      cfg_q <= `USSHP_CFG_RESET;
      rts_q <= 1'b0;
    end else if (pend_q && osc_tick_q && pd_n) begin
      if (word_q[15:14] == `USSHP_TYPE_WR_CFG) begin
        cfg_q <= word_q[13:0];
      end
      if (wr_data) begin
        rts_q <= word_q[`USSHP_DATA_RTS];
      end
    end
  end

  // A full FIFO holds the pending word, so back-pressure reaches the master through the room bit.
  usshp_fifo #(
    .W  (8),
    .D  (`USSHP_FIFO_DEPTH),
    .AW (`USSHP_FIFO_AW)
  ) u_fifo (
    .i_clk      (I_MCLK),
    .i_srst     (I_SRST),
    .i_flush    (!pd_n),
    .i_wr_valid (push_ok),
    .o_wr_ready (t_room),
    .i_wr_data  (word_q[7:0]),
    .o_rd_valid (f_valid),
    .i_rd_ready (!tx_busy_q && pd_n),
    .o_rd_data  (f_data)
  );
  // Transmitter: start bit, eight data bits, stop bit.
  always @(posedge I_MCLK) begin
    if (I_SRST || !pd_n) begin
      tx_busy_q <= 1'b0;
      tx_sh_q   <= 10'h3FF;
      tx_n_q    <= 4'h0;
      tx_tmr_q  <= 20'h00000;
      tx_q      <= 1'b1;
    end else if (!tx_busy_q) begin
      tx_q <= 1'b1;
      if (f_valid) begin
        tx_busy_q <= 1'b1;
        tx_sh_q   <= {1'b1, f_data, 1'b0};
        tx_n_q    <= 4'h0;
        tx_tmr_q  <= 20'h00000;
      end
    end else begin
      tx_q <= tx_sh_q[0];
      if (osc_tick_q) begin
        if (tx_tmr_q == bit_len - 20'h00001) begin
          tx_tmr_q <= 20'h00000;
          tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
          tx_n_q   <= tx_n_q + 4'h1;
          if (tx_n_q == 4'h9) begin
            tx_busy_q <= 1'b0;
          end
        end else begin
          tx_tmr_q <= tx_tmr_q + 20'h00001;
        end
      end
    end
  end

  // Receiver samples each bit at its middle.
  always @(posedge I_MCLK) begin
    if (I_SRST || !pd_n) begin
      rx_busy_q <= 1'b0;
      rx_n_q    <= 4'h0;
      rx_tmr_q  <= 20'h00000;
      rx_sh_q   <= 9'h000;
      rx_new_q  <= 1'b0;
    end else begin
      rx_new_q <= 1'b0;
      if (!rx_busy_q) begin
        if (!rx) begin
          rx_busy_q <= 1'b1;
          rx_n_q    <= 4'h0;
          rx_tmr_q  <= bit_len >> 1;
        end
      end else if (osc_tick_q) begin
        if (rx_tmr_q == bit_len - 20'h00001) begin
          rx_tmr_q <= 20'h00000;
          rx_n_q   <= rx_n_q + 4'h1;
          rx_sh_q  <= {rx, rx_sh_q[8:1]};
          if (rx_n_q == 4'h9) begin
            rx_busy_q <= 1'b0;
            rx_new_q  <= rx;
          end
        end else begin
          rx_tmr_q <= rx_tmr_q + 20'h00001;
        end
      end
    end
  end

  // A byte that lands in the clearing cycle keeps the flag set.
  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      r_q   <= 1'b0;
      rxd_q <= 8'h00;
    end else if (rx_new_q) begin
      r_q   <= 1'b1;
      rxd_q <= rx_sh_q[7:0];
    end else if (rx_clr) begin
      r_q <= 1'b0;
    end
  end

  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      rts_n_q    <= 1'b1;
      irq_n_q    <= 1'b0;
      irq_oe_n_q <= 1'b1;
    end else begin
      rts_n_q    <= ~rts_q;
      irq_n_q    <= 1'b0;
      irq_oe_n_q <= ~((r_q & cfg_q[`USSHP_CFG_RM]) | (t_room & cfg_q[`USSHP_CFG_TM]));
    end
  end
endmodule // usshp_port

/* core/usshp_defines.vh */
// Constants of the serial host port: frame types, field positions, reset values and dividers.
`ifndef USSHP_DEFINES_VH
`define USSHP_DEFINES_VH
`define USSHP_FRAME_BITS    5'h10
`define USSHP_TYPE_WR_CFG   2'h3
`define USSHP_TYPE_RD_CFG   2'h1
`define USSHP_TYPE_WR_DATA  2'h2
`define USSHP_TYPE_RD_DATA  2'h0
`define USSHP_CFG_RESET     14'h0000
`define USSHP_CFG_TM        11
`define USSHP_CFG_RM        10
`define USSHP_DATA_TE_N     10
`define USSHP_DATA_RTS      9
`define USSHP_OSC_DIV       8'h36
`define USSHP_OVERSAMPLE    20'h00010
`define USSHP_FIFO_DEPTH    16
`define USSHP_FIFO_AW       4
`endif

/* tb/usshp_props.sv */
// Checker of the serial host port pins.
`timescale 1ns/1ps
module usshp_props #(parameter [7:0] OSC_DIV = 8'h36) (
  input wire I_MCLK, I_SRST, I_SCLK, I_CS_N, I_DIN, I_POWER_DOWN_N, I_RX,
  input wire O_DOUT, O_DOUT_OE_N, O_IRQ_N, O_IRQ_OE_N, O_TX, O_RTS_N
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SRST);
  property p_rst; $past(I_SRST) |-> O_DOUT_OE_N && O_TX && O_RTS_N && O_IRQ_OE_N; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_oe_off; I_CS_N [*6] |-> O_DOUT_OE_N; endproperty
  a_oe_off: assert property (p_oe_off) else $error("data out driven while deselected");
  property p_oe_on; $fell(I_CS_N) ##1 (!I_CS_N) [*3] |=> !O_DOUT_OE_N; endproperty
  a_oe_on: assert property (p_oe_on) else $error("first bit late after select fall");
  property p_oe_hold; (!I_CS_N) [*6] |-> !O_DOUT_OE_N; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("data out released in a frame");
  // Output may only move at select fall or after a clock fall, never while the clock is high.
  property p_dout; (I_SCLK && !I_CS_N) [*5] |=> $stable(O_DOUT); endproperty
  a_dout: assert property (p_dout) else $error("data out moved while clock high");
  property p_irq; O_IRQ_OE_N || !O_IRQ_N; endproperty
  a_irq: assert property (p_irq) else $error("interrupt pin driven high");
  property p_rts; (!I_CS_N) [*8] |-> $stable(O_RTS_N); endproperty
  a_rts: assert property (p_rts) else $error("commit during shifting");
  property p_pd; (!I_POWER_DOWN_N) [*5] |-> O_TX; endproperty
  a_pd: assert property (p_pd) else $error("transmit not aborted in power down");
  c_frame: cover property ($fell(I_CS_N));
  c_rts: cover property ($fell(O_RTS_N));
  c_irq: cover property ($fell(O_IRQ_OE_N));
endmodule // usshp_props

/* tb/usshp_master.sv */
// Master side of the serial link: mode 0 frames of up to 16 clocks.
`timescale 1ns/1ps
module usshp_master (
  input  wire i_clk,
  input  wire i_miso,
  output reg  o_sclk,
  output reg  o_cs_n,
  output reg  o_din
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din = 1'b0;
  end
  task xfer(input [15:0] w, input integer n, output [15:0] r);
    integer k;
    begin
      r = 16'h0000;
      @(negedge i_clk);
      o_cs_n = 1'b0;
      for (k = 0; k < n; k = k + 1) begin
        o_din = w[15-k];
        #24 o_sclk = 1'b1;
        r = {r[14:0], i_miso};
        #24 o_sclk = 1'b0;
      end
      #24 o_cs_n = 1'b1;
      // A long gap lets the commit land before the next frame.
      repeat (12) @(negedge i_clk);
    end
  endtask
endmodule // usshp_master

/* tb/tb_top.sv */
// Testbench of the serial host port.
`timescale 1ns/1ps
module tb_top;
  reg        clk, srst, pd_n, rx, tgl;
  wire       sclk, cs_n, din, dout, oe_n, irq_n, irq_oe_n, tx, rts_n, miso, irq;
  reg [15:0] r;
  integer    error_cnt, num_checks;
  // Released line shows a changing pattern, pulled-up interrupt line.
  assign miso = oe_n ? tgl : dout;
  assign irq = irq_oe_n ? 1'b1 : irq_n;
  usshp_port #(.OSC_DIV(8'h02)) dut (.I_MCLK(clk), .I_SRST(srst), .I_SCLK(sclk), .I_CS_N(cs_n), .I_DIN(din),
    .I_POWER_DOWN_N(pd_n), .I_RX(rx), .O_DOUT(dout), .O_DOUT_OE_N(oe_n), .O_IRQ_N(irq_n),
    .O_IRQ_OE_N(irq_oe_n), .O_TX(tx), .O_RTS_N(rts_n));
  usshp_master m (.i_clk(clk), .i_miso(miso), .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) tgl <= ~tgl;
  task chk(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task t_cfg;
    begin
      chk({oe_n, tx, rts_n, irq}, 4'hF);
      m.xfer(16'hC120, 16, r);
      chk(r[14], 1'b1);
      m.xfer(16'h4000, 16, r);
      chk(r, 16'h4120);
      // Short frame must leave the stored value alone.
      m.xfer(16'hC3FF, 15, r);
      m.xfer(16'h4000, 16, r);
      chk(r, 16'h4120);
      m.xfer(16'hC920, 16, r);
      chk(irq, 1'b0);
      m.xfer(16'hC120, 16, r);
      chk(irq, 1'b1);
      $display("cfg done");
    end
  endtask
  task t_wdata;
    integer k;
    begin
      m.xfer(16'h82A5, 16, r);
      chk(rts_n, 1'b0);
      for (k = 0; k < 400 && tx !== 1'b0; k = k + 1)
        @(negedge clk);
      chk(tx, 1'b0);
      pd_n = 1'b0;
      repeat (5) @(negedge clk);
      chk(tx, 1'b1);
      pd_n = 1'b1;
      repeat (8) @(negedge clk);
      // A byte written with the send bit off must never reach the line.
      m.xfer(16'h845A, 16, r);
      chk(rts_n, 1'b1);
      chk(tx, 1'b1);
      $display("wdata done");
    end
  endtask
  task t_rx;
    reg [9:0] f;
    integer   k;
    begin
      m.xfer(16'hC520, 16, r);
      chk(irq, 1'b1);
      f = {1'b1, 8'hA5, 1'b0};
      for (k = 0; k < 10; k = k + 1) begin
        rx = f[k];
        repeat (32) @(negedge clk);
      end
      chk(irq, 1'b0);
      m.xfer(16'h0000, 16, r);
      chk(r, 16'hC0A5);
      chk(irq, 1'b1);
      m.xfer(16'h0000, 16, r);
      chk(r[15], 1'b0);
      $display("rx done");
    end
  endtask
  initial begin
    error_cnt = 0;
    num_checks = 0;
    srst = 1'b1;
    pd_n = 1'b1;
    rx = 1'b1;
    tgl = 1'b0;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    repeat (3) @(negedge clk);
    t_cfg;
    t_wdata;
    t_rx;
    wrap_up;
  end
  // The tests need about 11 us; a hang is cut well after that.
  initial begin
    #60000;
    error_cnt = error_cnt + 1;
    wrap_up;
  end
endmodule // tb_top
bind usshp_port usshp_props #(.OSC_DIV(OSC_DIV)) u_props (.*);
